// >>> adcseq_pkg.sv
`default_nettype none
package adcseq_pkg;
   // ---------------------------------------------------------------
   // Control byte layout
   // ---------------------------------------------------------------
   localparam int PD_HI_POS    = 7;
   localparam int PD_LO_POS    = 6;
   localparam int ACQ_MODE_POS = 5;
   localparam int IN_CFG_POS   = 4;
   localparam int POL_POS      = 3;
   localparam int CH_HI_POS    = 2;
   localparam int CH_LO_POS    = 0;

   // ---------------------------------------------------------------
   // Power-down field codes and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] PD_FULL      = 2'h0;
   localparam logic [1:0] PD_STANDBY   = 2'h1;
   localparam logic [1:0] PD_NORM_INT  = 2'h2;
   localparam logic [1:0] PD_NORM_EXT  = 2'h3;
   localparam logic       CLK_EXT_RST  = 1'h1;
   localparam logic [7:0] CTRL_RST     = 8'hC0;

   // ---------------------------------------------------------------
   // Timing counts
   // ---------------------------------------------------------------
   localparam int CONV_CYCLES     = 13;
   localparam int ACQ_FALL_EDGES  = 4;
   localparam int ACQ_TIME_NS     = 1000;
   localparam int REF_PERIOD_NS   = 10;
   localparam int ACQ_INT_CYCLES  = ACQ_TIME_NS / REF_PERIOD_NS;
   localparam int INT_CLK_DIV     = 14;
   localparam int RESULT_BITS     = 12;

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ADCSEQ_IDLE   = 2'b00,
      ADCSEQ_ACQ    = 2'b01,
      ADCSEQ_ACQEXT = 2'b10,
      ADCSEQ_CONV   = 2'b11
   } adcseq_state_t;
endpackage
`default_nettype wire

// >>> adcseq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adcseq_if;
   logic       cs_b;
   logic       wr_b;
   logic       rd_b;
   logic       high_byte_select;
   logic       conv_clk;
   logic [7:0] data_host;
   logic       data_host_oe;
   logic [7:0] data_dev;
   logic       data_dev_oe;
   logic       done_b;
   logic       done_oe;

   modport device (
      input  cs_b, wr_b, rd_b, high_byte_select, conv_clk, data_host, data_host_oe,
      output data_dev, data_dev_oe, done_b, done_oe
   );
   modport host (
      output cs_b, wr_b, rd_b, high_byte_select, conv_clk, data_host, data_host_oe,
      input  data_dev, data_dev_oe, done_b, done_oe
   );
endinterface
`default_nettype wire

// >>> adcseq_device.sv
//Contract
// - Write rising edge starts tracking.
// - External mode: next write edge holds.
// - Internal mode: hold on fourth falling edge.
// - Conversion lasts thirteen clock cycles.
// - New write aborts conversion, restarts acquisition.
// - Mode bit zero selects internal acquisition.
// - Internal acquisition end starts conversion.
// - Mode bit one: acquire until next write.
// - Second write, mode zero, starts conversion.
// - Host keeps channel bits across both writes.
// - Second write may change power-down field.
// - Host changes no other bits between writes.
// - Host starts conversion with gated write.
// - Single-ended: channel to plus, return minus.
// - Pseudo-differential: pair selects both inputs.
// - Successive approximation gives twelve-bit result.
// - Result read as low eight, high four.
// - Power-down field codes clock and power.
// - Bit layout: mode, config, polarity, channel.
// - Done flag low on result, cleared.
// - External clock mode after reset.
`timescale 1ns/10ps
`default_nettype none
module adcseq_device #(
   parameter int CONV_CYCLES = adcseq_pkg::CONV_CYCLES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   adcseq_if.device         bus,
   input  wire logic [11:0] comp_sample_i,
   output logic             track_o,
   output logic [2:0]       pos_channel_o,
   output logic [3:0]       neg_channel_o,
   output logic             polarity_o,
   output logic [1:0]       power_mode_o,
   output logic             ext_clk_mode_o
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] cs_s_q, hb_s_q;
   logic [2:0] wr_s_q, rd_s_q, ck_s_q;
   logic [7:0] dh_s1_q, dh_s2_q;

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cs_s_q  <= 2'h3;
         wr_s_q  <= 3'h7;
         rd_s_q  <= 3'h7;
         hb_s_q  <= 2'h0;
         ck_s_q  <= 3'h0;
         dh_s1_q <= 8'h00;
         dh_s2_q <= 8'h00;
      end
      else
      begin
         cs_s_q  <= {cs_s_q[0], bus.cs_b};
         wr_s_q  <= {wr_s_q[1:0], bus.wr_b};
         rd_s_q  <= {rd_s_q[1:0], bus.rd_b};
         hb_s_q  <= {hb_s_q[0], bus.high_byte_select};
         ck_s_q  <= {ck_s_q[1:0], bus.conv_clk};
         dh_s1_q <= bus.data_host;
         dh_s2_q <= dh_s1_q;
      end
   end

   // Data is taken from the same stage as the strobe's first high sample; the host holds it stable.
   logic write_ev;
   logic read_ev;
   assign write_ev = wr_s_q[1] && !wr_s_q[2] && !cs_s_q[1];
   assign read_ev  = !rd_s_q[1] && rd_s_q[2] && !cs_s_q[1];

   // ---------------------------------------------------------------
   // Conversion clock: external pin or internal divider
   // ---------------------------------------------------------------
   logic [3:0] div_q;
   logic       int_tick;
   logic       fall_ev;
   logic       rise_ev;

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         div_q <= 4'h0;
      else if (div_q == 4'(adcseq_pkg::INT_CLK_DIV - 1))
         div_q <= 4'h0;
      else
         div_q <= div_q + 4'h1;
   end
   assign int_tick = (div_q == 4'h0);
   assign fall_ev  = ext_clk_mode_o ? (!ck_s_q[1] && ck_s_q[2]) : int_tick;
   assign rise_ev  = ext_clk_mode_o ? (ck_s_q[1] && !ck_s_q[2]) : int_tick;

   // ---------------------------------------------------------------
   // Control byte fields
   // ---------------------------------------------------------------
   logic [1:0] pd_w;
   logic       acq_w;
   assign pd_w  = dh_s2_q[adcseq_pkg::PD_HI_POS:adcseq_pkg::PD_LO_POS];
   assign acq_w = dh_s2_q[adcseq_pkg::ACQ_MODE_POS];

   // Clock mode is kept when a power-down code is written.
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ext_clk_mode_o <= adcseq_pkg::CLK_EXT_RST;
         power_mode_o   <= adcseq_pkg::CTRL_RST[7:6];
      end
      else if (write_ev)
      begin
         power_mode_o <= pd_w;
         if (pd_w == adcseq_pkg::PD_NORM_INT)
            ext_clk_mode_o <= 1'h0;
         else if (pd_w == adcseq_pkg::PD_NORM_EXT)
            ext_clk_mode_o <= 1'h1;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   adcseq_pkg::adcseq_state_t st_q;
   logic [6:0] cnt_q;
   logic [3:0] bit_q;
   logic       cfg_ld;
   // A second write of an external acquisition keeps the latched selection.
   assign cfg_ld = write_ev && (st_q != adcseq_pkg::ADCSEQ_ACQEXT);

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_q  <= adcseq_pkg::ADCSEQ_IDLE;
         cnt_q <= 7'h00;
      end
      else if (write_ev)
      begin
         cnt_q <= 7'h00;
         if (st_q == adcseq_pkg::ADCSEQ_ACQEXT && !acq_w)
            st_q <= adcseq_pkg::ADCSEQ_CONV;
         else if (acq_w)
            st_q <= adcseq_pkg::ADCSEQ_ACQEXT;
         else
            st_q <= adcseq_pkg::ADCSEQ_ACQ;
      end
      else
      begin
         case (st_q)
            adcseq_pkg::ADCSEQ_ACQ:
            begin
               if (fall_ev)
               begin
                  if (cnt_q == 7'(adcseq_pkg::ACQ_FALL_EDGES - 1))
                  begin
                     st_q  <= adcseq_pkg::ADCSEQ_CONV;
                     cnt_q <= 7'h00;
                  end
                  else
                     cnt_q <= cnt_q + 7'h01;
               end
            end
            adcseq_pkg::ADCSEQ_CONV:
            begin
               if (rise_ev)
               begin
                  if (cnt_q == 7'(CONV_CYCLES - 1))
                     st_q <= adcseq_pkg::ADCSEQ_IDLE;
                  cnt_q <= cnt_q + 7'h01;
               end
            end
            default: ;
         endcase
      end
   end

   // Track/hold follows the state.
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         track_o <= 1'h0;
      else if (write_ev && !(st_q == adcseq_pkg::ADCSEQ_ACQEXT && !acq_w))
         track_o <= 1'h1;
      else if (st_q == adcseq_pkg::ADCSEQ_CONV || st_q == adcseq_pkg::ADCSEQ_IDLE)
         track_o <= 1'h0;
   end

   // ---------------------------------------------------------------
   // Multiplexer routing
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pos_channel_o <= 3'h0;
         neg_channel_o <= 4'h8;
         polarity_o    <= 1'h1;
      end
      else if (cfg_ld)
      begin
         polarity_o    <= dh_s2_q[adcseq_pkg::POL_POS];
         pos_channel_o <= dh_s2_q[adcseq_pkg::CH_HI_POS:adcseq_pkg::CH_LO_POS];
         if (dh_s2_q[adcseq_pkg::IN_CFG_POS])
            neg_channel_o <= 4'h8;
         else
            neg_channel_o <= {1'h0, dh_s2_q[2:1], ~dh_s2_q[0]};
      end
   end

   // ---------------------------------------------------------------
   // Successive approximation and result
   // ---------------------------------------------------------------
   logic [11:0] trial_q, result_q;
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         trial_q  <= 12'h000;
         result_q <= 12'h000;
         bit_q    <= 4'hB;
      end
      else if (st_q != adcseq_pkg::ADCSEQ_CONV)
      begin
         trial_q <= 12'h000;
         bit_q   <= 4'hB;
      end
      else if (rise_ev && cnt_q >= 7'h01 && cnt_q <= 7'(adcseq_pkg::RESULT_BITS))
      begin
         if (comp_sample_i[bit_q])
            trial_q[bit_q] <= 1'h1;
         if (bit_q == 4'h0)
            result_q <= trial_q | {11'h000, comp_sample_i[0]};
         else
            bit_q <= bit_q - 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Completion flag and read-back
   // ---------------------------------------------------------------
   logic conv_end;
   assign conv_end = st_q == adcseq_pkg::ADCSEQ_CONV && rise_ev
                     && cnt_q == 7'(CONV_CYCLES - 1) && !write_ev;
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         bus.done_b <= 1'h1;
      else if (conv_end)
         bus.done_b <= 1'h0;
      else if (read_ev || write_ev)
         bus.done_b <= 1'h1;
   end
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         bus.data_dev    <= 8'h00;
         bus.data_dev_oe <= 1'h0;
         bus.done_oe     <= 1'h0;
      end
      else
      begin
         bus.done_oe     <= !cs_s_q[1];
         bus.data_dev_oe <= !cs_s_q[1] && !rd_s_q[1];
         bus.data_dev    <= hb_s_q[1] ? {4'h0, result_q[11:8]} : result_q[7:0];
      end
   end
endmodule // adcseq_device
`default_nettype wire

// >>> adcseq_host.sv
`timescale 1ns/10ps
`default_nettype none
module adcseq_host (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   adcseq_if.host           bus,
   input  wire logic        start_i,
   input  wire logic        finish_i,
   input  wire logic [7:0]  ctrl_i,
   output logic             busy_o,
   output logic [11:0]      result_o,
   output logic             result_valid_o
);
   // Each strobe phase lasts STEP+1 cycles so the device's synchronisers see it.
   localparam logic [2:0] STEP = 3'h6;
   logic [2:0] ph_q;
   logic [3:0] seq_q;
   logic [7:0] held_q;
   logic [1:0] done_s_q;
   logic       rd_pend_q;

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         done_s_q <= 2'h3;
      else
         done_s_q <= {done_s_q[0], bus.done_b};
   end

   // seq: 1-2 write, 3-6 low/high read, 0 idle.
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         seq_q <= 4'h0;
         ph_q  <= 3'h0;
         held_q <= adcseq_pkg::CTRL_RST;
         rd_pend_q <= 1'h0;
         result_o <= 12'h000;
         result_valid_o <= 1'h0;
      end
      else
      begin
         result_valid_o <= 1'h0;
         if (seq_q == 4'h0)
         begin
            if (start_i)
            begin
               held_q <= ctrl_i;
               seq_q  <= 4'h1;
            end
            else if (finish_i)
            begin
               // The closing write clears the mode bit and may carry a new power-down field.
               held_q[adcseq_pkg::ACQ_MODE_POS] <= 1'h0;
               held_q[adcseq_pkg::PD_HI_POS:adcseq_pkg::PD_LO_POS] <=
                  ctrl_i[adcseq_pkg::PD_HI_POS:adcseq_pkg::PD_LO_POS];
               seq_q <= 4'h1;
            end
            else if (!done_s_q[1] && !rd_pend_q)
            begin
               rd_pend_q <= 1'h1;
               seq_q     <= 4'h3;
            end
         end
         else if (ph_q == STEP)
         begin
            ph_q <= 3'h0;
            if (seq_q == 4'h2 || seq_q == 4'h6)
               seq_q <= 4'h0;
            else
               seq_q <= seq_q + 4'h1;
            if (seq_q == 4'h4)
               result_o[7:0] <= bus.data_dev;
            if (seq_q == 4'h6)
            begin
               result_o[11:8] <= bus.data_dev[3:0];
               result_valid_o <= 1'h1;
               rd_pend_q <= 1'h0;
            end
         end
         else
            ph_q <= ph_q + 3'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         bus.cs_b <= 1'h1;
         bus.wr_b <= 1'h1;
         bus.rd_b <= 1'h1;
         bus.high_byte_select <= 1'h0;
         bus.data_host <= adcseq_pkg::CTRL_RST;
         bus.data_host_oe <= 1'h0;
         bus.conv_clk <= 1'h0;
         busy_o <= 1'h0;
      end
      else
      begin
         bus.cs_b <= (seq_q == 4'h0);
         bus.wr_b <= (seq_q != 4'h1);
         bus.rd_b <= !(seq_q == 4'h3 || seq_q == 4'h5);
         bus.high_byte_select <= (seq_q >= 4'h5);
         bus.data_host <= held_q;
         bus.data_host_oe <= (seq_q == 4'h1 || seq_q == 4'h2);
         bus.conv_clk <= ~bus.conv_clk;
         busy_o <= (seq_q != 4'h0);
      end
   end
endmodule // adcseq_host
`default_nettype wire

// >>> adcseq_props.sv
`timescale 1ns/10ps
`default_nettype none
module adcseq_props (
   input wire logic       ref_clk_i,
   input wire logic       rst_b_i,
   input wire logic       cs_b,
   input wire logic       wr_b,
   input wire logic       rd_b,
   input wire logic       conv_clk,
   input wire logic [7:0] data_host,
   input wire logic       data_host_oe,
   input wire logic       data_dev_oe,
   input wire logic       done_b
);
   // ---------------------------------------------------------------
   // Conversion clock count since the last accepted write
   // ---------------------------------------------------------------
   // Counted from the pin edge, so it can only run ahead of the device.
   logic [4:0] rise_cnt_q;

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rise_cnt_q <= 5'h00;
      else if ($rose(wr_b) && !cs_b)
         rise_cnt_q <= 5'h00;
      else if ($rose(conv_clk) && rise_cnt_q != 5'h1F)
         rise_cnt_q <= rise_cnt_q + 5'h01;
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence wr_taken_s;
      $rose(wr_b) && !cs_b;
   endsequence

   sequence wr_low_s;
      $fell(wr_b) ##1 !wr_b [*4];
   endsequence

   done_clear_a: assert property (wr_taken_s |-> ##[1:5] done_b)
      else $error("done flag not released after a write");
   done_read_a: assert property ($fell(rd_b) && !cs_b |-> ##[1:5] done_b)
      else $error("done flag not released after a read");
   conv_len_a: assert property ($fell(done_b) |-> rise_cnt_q >= 5'h0D)
      else $error("result ready before thirteen clock cycles");
   wr_pulse_a: assert property (wr_low_s |-> ##[1:3] wr_b)
      else $error("write strobe has the wrong length");
   wr_cs_a: assert property ($rose(wr_b) |-> !cs_b && data_host_oe)
      else $error("write strobe without select or data");
   wr_data_a: assert property ($rose(wr_b) |-> $stable(data_host))
      else $error("control byte moved at the write edge");
   dev_oe_a: assert property (data_dev_oe |-> !cs_b || !$past(cs_b) || !$past(cs_b, 2))
      else $error("device drives data while deselected");
   bus_free_a: assert property (!(data_dev_oe && data_host_oe))
      else $error("both ends drive the data bus");
   rd_cs_a: assert property ($fell(rd_b) |-> !cs_b)
      else $error("read strobe without select");
endmodule // adcseq_props
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        ref_clk   = 1'b0;
   logic        rst_b     = 1'b0;
   logic        start     = 1'b0;
   logic        finish    = 1'b0;
   logic [7:0]  ctrl      = 8'h00;
   logic [11:0] comp      = 12'h000;
   logic        ext_exp   = 1'b1;
   logic        track;
   logic        pol;
   logic        ext_mode;
   logic        busy;
   logic        rvalid;
   logic [2:0]  pos_ch;
   logic [3:0]  neg_ch;
   logic [1:0]  pwr;
   logic [11:0] result;
   int          bad_count = 0;
   int          compares  = 0;

   adcseq_if bus_if ();

   always #5 ref_clk = ~ref_clk;

   adcseq_device #(.CONV_CYCLES(adcseq_pkg::CONV_CYCLES)) adcseq_device_inst (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .bus(bus_if), .comp_sample_i(comp),
      .track_o(track), .pos_channel_o(pos_ch), .neg_channel_o(neg_ch),
      .polarity_o(pol), .power_mode_o(pwr), .ext_clk_mode_o(ext_mode));

   adcseq_host adcseq_host_inst (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .bus(bus_if), .start_i(start),
      .finish_i(finish), .ctrl_i(ctrl), .busy_o(busy), .result_o(result),
      .result_valid_o(rvalid));

   adcseq_props adcseq_props_inst (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .cs_b(bus_if.cs_b), .wr_b(bus_if.wr_b),
      .rd_b(bus_if.rd_b), .conv_clk(bus_if.conv_clk), .data_host(bus_if.data_host),
      .data_host_oe(bus_if.data_host_oe), .data_dev_oe(bus_if.data_dev_oe),
      .done_b(bus_if.done_b));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [3:0] neg_exp(input logic [7:0] c);
      return c[4] ? 4'h8 : {1'b0, c[2:0] ^ 3'h1};
   endfunction

   // The host may stay busy; a write is still sent after a short wait.
   task automatic send(input logic [7:0] c, input logic fin);
      int n;
      n = 0;
      while (busy === 1'b1 && n < 20)
      begin
         @(negedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      ctrl <= c;
      start <= !fin;
      finish <= fin;
      if (c[7])
         ext_exp = c[6];
      @(posedge ref_clk);
      start <= 1'b0;
      finish <= 1'b0;
   endtask

   task automatic wait_track(input logic v, output int n);
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (track !== v && n < 3000);
   endtask

   task automatic wait_valid();
      int n;
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (rvalid !== 1'b1 && n < 3000);
      check({11'h000, rvalid}, 12'h001);
   endtask

   task automatic convert(input logic [7:0] c, input logic ext);
      int n;
      @(posedge ref_clk);
      comp <= 12'($urandom);
      send(c | {2'b00, ext, 5'h00}, 1'b0);
      wait_track(1'b1, n);
      check({11'h000, track}, 12'h001);
      check({9'h000, pos_ch}, {9'h000, c[2:0]});
      check({8'h00, neg_ch}, {8'h00, neg_exp(c)});
      check({11'h000, pol}, {11'h000, c[3]});
      check({10'h000, pwr}, {10'h000, c[7:6]});
      check({11'h000, ext_mode}, {11'h000, ext_exp});
      if (ext)
      begin
         repeat (150) @(negedge ref_clk);
         check({11'h000, track}, 12'h001);
         send({1'b0, c[6], 1'b0, c[4:0]}, 1'b1);
         repeat (2) @(negedge ref_clk);
         check({4'h0, bus_if.data_host}, {4'h0, 1'b0, c[6], 1'b0, c[4:0]});
      end
      wait_track(1'b0, n);
      check({11'h000, n < 80}, 12'h001);
      wait_valid();
      check(result, comp);
      check({9'h000, pos_ch}, {9'h000, c[2:0]});
      check({11'h000, ext_mode}, {11'h000, ext_exp});
      check({10'h000, pwr}, {10'h000, ext ? {1'b0, c[6]} : c[7:6]});
      $display("conversion test done, control %h", c);
   endtask

   task automatic summarize();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin : main
      int n;
      void'($urandom(69722));
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      check({11'h000, track}, 12'h000);
      check({11'h000, ext_mode}, 12'h001);
      check({10'h000, pwr}, 12'h003);
      check({11'h000, bus_if.done_b}, 12'h001);
      check({11'h000, bus_if.done_oe}, 12'h000);
      $display("reset test done");
      for (int i = 0; i < 16; i++)
         convert({1'b1, i[3] ^ i[0], 1'b0, i[3], 1'($urandom), i[2:0]}, 1'b0);
      for (int j = 0; j < 2; j++)
         convert({1'b1, j[0], 1'b0, 5'($urandom)}, 1'b1);
      @(posedge ref_clk);
      comp <= 12'h35A;
      send(8'hD9, 1'b0);
      wait_track(1'b0, n);
      repeat (4) @(negedge ref_clk);
      @(posedge ref_clk);
      comp <= 12'hA5C;
      send(8'hDA, 1'b0);
      wait_valid();
      check(result, 12'hA5C);
      check({9'h000, pos_ch}, 12'h002);
      $display("abort test done");
      summarize();
   end

   initial
   begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      summarize();
   end
endmodule // tb_top
`default_nettype wire
